// [src/wake_pkg.sv]
// constants for the port pin stop-wake block
`default_nettype none
package wake_pkg;
  // register indices; byte address is four times the index
  localparam logic [11:0] IDX_WAKE_REF_STATUS = 12'hf0a;
  localparam logic [11:0] IDX_PORT3_WAKE_SEL  = 12'hf0e;
  localparam logic [11:0] IDX_PORT2_WAKE_SEL  = 12'hf0c;
  localparam logic [11:0] IDX_GATED_WAKE_SEL  = 12'hf0d;
  localparam logic [11:0] IDX_PORT2_DATA      = 12'hf10;
  localparam logic [11:0] IDX_PORT3_DATA      = 12'hf11;
  localparam logic [11:0] IDX_PORT3_MODE      = 12'hf12;
  localparam logic [11:0] IDX_PORT2_DIR       = 12'hf13;
  localparam logic [11:0] IDX_PORT3_DIR       = 12'hf14;
  localparam logic [11:0] IDX_IRQ_STATUS      = 12'hf15;
  localparam logic [11:0] IDX_IRQ_MASK        = 12'hf16;
  // wake_reference_status fields
  localparam int STAT_IRQ_EN = 4;
  localparam int STAT_P3_LO  = 2;
  localparam int STAT_P2_LO  = 0;
  localparam logic [1:0] REF_NONE  = 2'h0;
  localparam logic [1:0] REF_READ  = 2'h1;
  localparam logic [1:0] REF_WRITE = 2'h2;
  localparam logic [1:0] REF_RSVD  = 2'h3;
  // gated_wake_select fields
  localparam int GATE_LEVEL  = 6;
  localparam int GATE_SRC_LO = 2;
  // port3_mode_reg bit that also opens the interrupt path
  localparam int P3M_IRQ_BIT = 1;
  // interrupt status bits
  localparam int IRQ_P3 = 0;
  localparam int IRQ_P2 = 1;
  localparam int IRQ_GT = 2;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
endpackage
`default_nettype wire

// [src/wake_ref_if.sv]
// carrier between control logic and a pin compare unit
`default_nettype none
interface wake_ref_if #(parameter int W = 4);
  logic [W-1:0] pins;
  logic [W-1:0] ref_val;
  logic [W-1:0] select;
  logic         use_ref;
  logic         event_hit;
  modport cmp (input pins, ref_val, select, use_ref, output event_hit);
  modport ctl (output pins, ref_val, select, use_ref, input event_hit);
endinterface
`default_nettype wire

// [src/pin_sync.sv]
// two-flop synchroniser for pin inputs
`default_nettype none
module pin_sync #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // async pins in, synced out
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_q <= '0;
      q_o    <= '0;
    end
    else
    begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule
`default_nettype wire

// [src/wake_compare.sv]
// per-pin wake compare: low level or change from reference
`default_nettype none
module wake_compare #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // compare inputs and registered hit
  wake_ref_if.cmp   port
);
  // without a reference a selected pin wakes on zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      port.event_hit <= 1'b0;
    else if (port.use_ref)
      port.event_hit <= |(port.select & (port.pins ^ port.ref_val));
    else
      port.event_hit <= |(port.select & ~port.pins);
  end
endmodule
`default_nettype wire

// [src/port_pin_stop_wake.sv]
// stop-wake event logic with wishbone register access
`default_nettype none
module port_pin_stop_wake
  import wake_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [13:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // port pins
  input  wire logic [3:0]  port3_pins_i,
  input  wire logic [7:0]  port2_pins_i,
  input  wire logic [7:0]  port0_pins_i,
  // port data outputs
  output logic      [3:0]  port3_out_o,
  output logic      [7:0]  port2_out_o,
  // wake and interrupt
  output logic             stop_wake_event_o,
  output logic             wake_irq_line_o
);
  logic [3:0] p3_s;
  logic [7:0] p2_s;
  logic [7:0] p0_s;
  logic [3:0] sel3_q;
  logic [7:0] sel2_q;
  logic [3:0] gated_q;
  logic [4:0] stat_q;
  logic [1:0] p3st_q;
  logic [1:0] p2st_q;
  logic       irqen_q;
  logic [3:0] ref3_q;
  logic [7:0] ref2_q;
  logic [7:0] p3m_q;
  logic [7:0] p2dir_q;
  logic [3:0] p3dir_q;
  logic [2:0] ist_q;
  logic [2:0] imask_q;
  logic       ack_q;
  logic [7:0] dat_q;
  logic [7:0] rd_d;
  logic       gate_hit_q;
  logic       gate_d;
  logic [2:0] hits;
  logic       acc;
  logic       wr;
  logic       rd;
  logic [11:0] idx;

  wake_ref_if #(.W(4)) p3_if ();
  wake_ref_if #(.W(8)) p2_if ();

  // pins pass two flops before any logic
  pin_sync #(.W(4)) u_sync3 (.clk_i(clk_i), .rst_i(rst_i),
    .d_i(port3_pins_i), .q_o(p3_s));
  pin_sync #(.W(8)) u_sync2 (.clk_i(clk_i), .rst_i(rst_i),
    .d_i(port2_pins_i), .q_o(p2_s));
  pin_sync #(.W(8)) u_sync0 (.clk_i(clk_i), .rst_i(rst_i),
    .d_i(port0_pins_i), .q_o(p0_s));

  // status byte view; each field has a single writing process
  assign stat_q = {irqen_q, p3st_q, p2st_q};

  // compare units
  assign p3_if.pins    = p3_s;
  assign p3_if.ref_val = ref3_q;
  assign p3_if.select  = sel3_q;
  assign p3_if.use_ref = (stat_q[STAT_P3_LO+:2] != REF_NONE);
  assign p2_if.pins    = p2_s;
  assign p2_if.ref_val = ref2_q;
  assign p2_if.select  = sel2_q;
  assign p2_if.use_ref = (stat_q[STAT_P2_LO+:2] != REF_NONE);
  wake_compare #(.W(4)) u_cmp3 (.clk_i(clk_i), .rst_i(rst_i),
    .port(p3_if));
  wake_compare #(.W(8)) u_cmp2 (.clk_i(clk_i), .rst_i(rst_i),
    .port(p2_if));

  // reduce over bits not ignored; ignored bits are neutral
  function automatic logic gate_reduce(input logic [7:0] v,
                                       input logic [7:0] keep,
                                       input logic       is_nand);
    logic r;
    r = is_nand ? ~&(v | ~keep) : ~|(v & keep);
    return r;
  endfunction

  // wishbone address decode on word index
  function automatic logic hit(input logic [11:0] a,
                               input logic [11:0] i);
    return a == i;
  endfunction

  // gated source: pins driven or already selected are dropped
  always_comb
  begin
    logic [7:0] k2;
    logic [7:0] k3;
    logic [7:0] v3;
    logic       o;
    k2 = ~p2dir_q & ~sel2_q;
    k3 = {4'h0, ~p3dir_q & ~sel3_q};
    v3 = {4'h0, p3_s};
    o  = 1'b0;
    case (gated_q[2:0])
      3'h1: o = gate_reduce(p2_s, k2 & 8'h0f, 1'b1);
      3'h2: o = gate_reduce(p2_s, k2, 1'b1);
      3'h3: o = gate_reduce(v3, k3 & 8'h0e, 1'b0);
      3'h4: o = gate_reduce(v3, k3 & 8'h0e, 1'b1);
      3'h5: o = gate_reduce({p0_s[7], p0_s[0], v3[5:0]},
                            {2'h3, k3[5:1] & 5'h07, 1'b0}, 1'b0);
      3'h6: o = gate_reduce({p0_s[7], p0_s[0], v3[5:0]},
                            {2'h3, k3[5:1] & 5'h07, 1'b0}, 1'b1);
      3'h7: o = gate_reduce({1'b0, p2_s[2:0], v3[3:1], 1'b0},
                            {1'b0, k2[2:0], k3[3:1], 1'b0}, 1'b1);
      default: o = ~gated_q[3];
    endcase
    gate_d = (gated_q[2:0] != 3'h0) && (o == gated_q[3]);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      gate_hit_q <= 1'b0;
    else
      gate_hit_q <= gate_d;
  end

  // any source wakes the part
  assign hits = {gate_hit_q, p2_if.event_hit, p3_if.event_hit};

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      stop_wake_event_o <= 1'b0;
    else
      stop_wake_event_o <= |hits;
  end

  // bus access happens at the edge where ack is high
  assign idx      = wb_adr_i[13:2];
  assign acc      = wb_cyc_i && wb_stb_i && ack_q;
  assign wr       = acc && wb_we_i && wb_sel_i[0];
  assign rd       = acc && !wb_we_i;
  assign wb_ack_o = ack_q;
  assign wb_dat_o = {24'h0, dat_q};

  // one wait state; ack drops after one cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_q <= 1'b0;
    else
      ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
  end

  // read mux; unmapped and reserved bits read zero
  always_comb
  begin
    rd_d = RST_BYTE;
    if (hit(idx, IDX_WAKE_REF_STATUS))
      rd_d = {3'h0, stat_q};
    else if (hit(idx, IDX_PORT3_WAKE_SEL))
      rd_d = {4'h0, sel3_q};
    else if (hit(idx, IDX_PORT2_WAKE_SEL))
      rd_d = sel2_q;
    else if (hit(idx, IDX_GATED_WAKE_SEL))
      rd_d = {1'b0, gated_q[3], 1'b0, gated_q[2:0], 2'h0};
    else if (hit(idx, IDX_PORT2_DATA))
      rd_d = p2_s;
    else if (hit(idx, IDX_PORT3_DATA))
      rd_d = {4'h0, p3_s};
    else if (hit(idx, IDX_PORT3_MODE))
      rd_d = p3m_q;
    else if (hit(idx, IDX_PORT2_DIR))
      rd_d = p2dir_q;
    else if (hit(idx, IDX_PORT3_DIR))
      rd_d = {4'h0, p3dir_q};
    else if (hit(idx, IDX_IRQ_STATUS))
      rd_d = {5'h0, ist_q};
    else if (hit(idx, IDX_IRQ_MASK))
      rd_d = {5'h0, imask_q};
  end

  // read data captured when the request arrives
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_q <= RST_BYTE;
    else if (wb_cyc_i && wb_stb_i && !ack_q)
      dat_q <= rd_d;
  end

  // select and enable registers; reset only, never cleared on wake
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sel3_q  <= 4'h0;
      sel2_q  <= RST_BYTE;
      gated_q <= 4'h0;
      irqen_q <= 1'b0;
    end
    else if (wr)
    begin
      if (hit(idx, IDX_PORT3_WAKE_SEL))
        sel3_q <= wb_dat_i[3:0];
      if (hit(idx, IDX_PORT2_WAKE_SEL))
        sel2_q <= wb_dat_i[7:0];
      if (hit(idx, IDX_GATED_WAKE_SEL))
        gated_q <= {wb_dat_i[GATE_LEVEL], wb_dat_i[GATE_SRC_LO+:3]};
      if (hit(idx, IDX_WAKE_REF_STATUS))
        irqen_q <= wb_dat_i[STAT_IRQ_EN];
    end
  end

  // port data, mode and direction registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      port3_out_o <= 4'h0;
      port2_out_o <= RST_BYTE;
      p3m_q       <= RST_BYTE;
      p2dir_q     <= RST_BYTE;
      p3dir_q     <= 4'h0;
    end
    else if (wr)
    begin
      if (hit(idx, IDX_PORT3_DATA))
        port3_out_o <= wb_dat_i[3:0];
      if (hit(idx, IDX_PORT2_DATA))
        port2_out_o <= wb_dat_i[7:0];
      if (hit(idx, IDX_PORT3_MODE))
        p3m_q <= wb_dat_i[7:0];
      if (hit(idx, IDX_PORT2_DIR))
        p2dir_q <= wb_dat_i[7:0];
      if (hit(idx, IDX_PORT3_DIR))
        p3dir_q <= wb_dat_i[3:0];
    end
  end

  // port 3 reference; a read keeps the nibble it returned, not later pins
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ref3_q <= 4'h0;
      p3st_q <= REF_NONE;
    end
    else if (rd && hit(idx, IDX_PORT3_DATA))
    begin
      ref3_q <= dat_q[3:0];
      p3st_q <= REF_READ;
    end
    else if (wr && hit(idx, IDX_PORT3_DATA))
    begin
      ref3_q <= wb_dat_i[3:0];
      p3st_q <= REF_WRITE;
    end
    else if (wr && hit(idx, IDX_WAKE_REF_STATUS)
             && wb_dat_i[STAT_P3_LO+:2] != REF_RSVD)
      p3st_q <= wb_dat_i[STAT_P3_LO+:2];
  end

  // port 2 reference and status
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ref2_q <= RST_BYTE;
      p2st_q <= REF_NONE;
    end
    else if (rd && hit(idx, IDX_PORT2_DATA))
    begin
      ref2_q <= dat_q;
      p2st_q <= REF_READ;
    end
    else if (wr && hit(idx, IDX_PORT2_DATA))
    begin
      ref2_q <= wb_dat_i[7:0];
      p2st_q <= REF_WRITE;
    end
    else if (wr && hit(idx, IDX_WAKE_REF_STATUS)
             && wb_dat_i[STAT_P2_LO+:2] != REF_RSVD)
      p2st_q <= wb_dat_i[STAT_P2_LO+:2];
  end

  // sticky status, write one to clear; a new hit wins
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ist_q   <= 3'h0;
      imask_q <= 3'h0;
    end
    else
    begin
      if (wr && hit(idx, IDX_IRQ_STATUS))
        ist_q <= (ist_q & ~wb_dat_i[2:0]) | hits;
      else
        ist_q <= ist_q | hits;
      if (wr && hit(idx, IDX_IRQ_MASK))
        imask_q <= wb_dat_i[2:0];
    end
  end

  // irq path open by enable bit, or by port3 mode bit
  assign wake_irq_line_o = |(ist_q & imask_q)
    && (stat_q[STAT_IRQ_EN] || p3m_q[P3M_IRQ_BIT]);

  // checks
  ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_q |=> !ack_q) else $error("ack held more than one cycle");
  read_ref_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd && hit(idx, IDX_PORT3_DATA) |=>
      stat_q[3:2] == REF_READ && ref3_q == $past(dat_q[3:0]))
    else $error("port3 read did not latch reference");
  write_ref_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && hit(idx, IDX_PORT3_DATA) |=>
      stat_q[3:2] == REF_WRITE && ref3_q == $past(wb_dat_i[3:0]))
    else $error("port3 write did not latch reference");
  zero_wake_a: assert property (@(posedge clk_i) disable iff (rst_i)
    stat_q[3:2] == REF_NONE && |(sel3_q & ~p3_s) |-> ##2
      stop_wake_event_o) else $error("low pin gave no wake");
  diff_wake_a: assert property (@(posedge clk_i) disable iff (rst_i)
    stat_q[3:2] != REF_NONE && |(sel3_q & (p3_s ^ ref3_q)) |-> ##2
      stop_wake_event_o) else $error("changed pin gave no wake");
  no_spurious_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !(|hits) |=> !stop_wake_event_o)
    else $error("wake without a source");
  sel_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && hit(idx, IDX_PORT3_WAKE_SEL) |=>
      sel3_q == $past(wb_dat_i[3:0])) else $error("select not stored");
  irq_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
    hits[IRQ_P3] && imask_q[IRQ_P3] && stat_q[STAT_IRQ_EN]
      && $stable(stat_q) |=> wake_irq_line_o)
    else $error("wake did not raise interrupt");
  stat_rsvd_a: assert property (@(posedge clk_i) disable iff (rst_i)
    stat_q[3:2] != REF_RSVD) else $error("reserved status code held");
  gated_mask_a: assert property (@(posedge clk_i) disable iff (rst_i)
    gated_q[2:0] == 3'h3 && (sel3_q[3:1] | p3dir_q[3:1]) == 3'h7 |=>
      gate_hit_q == $past(gated_q[3])) else $error("ignored pin counted");
endmodule
`default_nettype wire

// [sim/port_pins_model.sv]
// behavioural model of the external port pins
`default_nettype none
module port_pins_model (
  // clock
  input  wire logic       clk_i,
  // levels asked for by the bench
  input  wire logic [3:0] p3_lvl_i,
  input  wire logic [7:0] p2_lvl_i,
  // pins as the block sees them
  output logic      [3:0] port3_pins_o,
  output logic      [7:0] port2_pins_o,
  output logic      [7:0] port0_pins_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // pins move just after an edge, never mid-cycle
  always_ff @(posedge clk_i)
  begin
    port3_pins_o <= p3_lvl_i;
    port2_pins_o <= p2_lvl_i;
  end
  // port 0 idles high so no gated source sees a low
  assign port0_pins_o = 8'hff;
endmodule
`default_nettype wire

// [sim/port_pin_stop_wake_bench.sv]
// self-checking bench for the port pin stop-wake block
`default_nettype none
module port_pin_stop_wake_logic_bench
  import wake_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [13:0] wb_adr_i;
  logic [3:0]  wb_sel_i, p3_lvl, port3_pins_i, port3_out_o;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [7:0]  p2_lvl, port2_pins_i, port0_pins_i, port2_out_o;
  logic        stop_wake_event_o, wake_irq_line_o;
  int          num_errors, checks;

  port_pin_stop_wake u_port_pin_stop_wake (
    .clk_i             (clk_i),
    .rst_i             (rst_i),
    .wb_cyc_i          (wb_cyc_i),
    .wb_stb_i          (wb_stb_i),
    .wb_we_i           (wb_we_i),
    .wb_adr_i          (wb_adr_i),
    .wb_sel_i          (wb_sel_i),
    .wb_dat_i          (wb_dat_i),
    .wb_dat_o          (wb_dat_o),
    .wb_ack_o          (wb_ack_o),
    .port3_pins_i      (port3_pins_i),
    .port2_pins_i      (port2_pins_i),
    .port0_pins_i      (port0_pins_i),
    .port3_out_o       (port3_out_o),
    .port2_out_o       (port2_out_o),
    .stop_wake_event_o (stop_wake_event_o),
    .wake_irq_line_o   (wake_irq_line_o)
  );
  port_pins_model u_port_pins_model (.clk_i(clk_i), .p3_lvl_i(p3_lvl),
    .p2_lvl_i(p2_lvl), .port3_pins_o(port3_pins_i),
    .port2_pins_o(port2_pins_i), .port0_pins_o(port0_pins_i));

  // free-running clock, 4 ns
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic test_done();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one classic cycle; request held until the rising edge that sees ack
  task automatic wb(input logic we, input logic [11:0] idx,
                    input logic [7:0] wd);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {idx, 2'h0};
    wb_dat_i <= {24'h0, wd};
    n = 0;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge clk_i);
    end
    if (n == 20)
    begin
      num_errors++;
      test_done();
    end
    // read data taken at the ack edge, then the request drops
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic rdchk(input string what, input logic [11:0] idx,
                       input logic [7:0] exp);
    wb(1'b0, idx, 8'h00);
    check(what, rd, {24'h0, exp});
  endtask

  // pins settle through sync and compare within a few cycles
  task automatic pins_wake(input logic [3:0] p, input logic exp);
    @(posedge clk_i);
    p3_lvl <= p;
    repeat (8) @(negedge clk_i);
    check("wake", {31'h0, stop_wake_event_o}, {31'h0, exp});
  endtask

  task automatic t_reset();
    rdchk("status", IDX_WAKE_REF_STATUS, 8'h00);
    rdchk("select", IDX_PORT3_WAKE_SEL, 8'h00);
    rdchk("unmapped", 12'h0ab, 8'h00);
    check("wake", {31'h0, stop_wake_event_o}, 32'h0);
    check("irq", {31'h0, wake_irq_line_o}, 32'h0);
  endtask

  task automatic t_select();
    pins_wake(4'hf, 1'b0);
    wb(1'b1, IDX_PORT3_WAKE_SEL, 8'hf2);
    rdchk("select", IDX_PORT3_WAKE_SEL, 8'h02);
    pins_wake(4'hf, 1'b0);
    pins_wake(4'hd, 1'b1);
    pins_wake(4'he, 1'b0);
  endtask

  task automatic t_write_ref();
    wb(1'b1, IDX_PORT3_WAKE_SEL, 8'h0f);
    wb(1'b1, IDX_PORT3_DATA, 8'h05);
    rdchk("status", IDX_WAKE_REF_STATUS, 8'h08);
    check("p3 out", {28'h0, port3_out_o}, 32'h5);
    pins_wake(4'h5, 1'b0);
    pins_wake(4'h4, 1'b1);
    pins_wake(4'hd, 1'b1);
  endtask

  task automatic t_read_ref();
    pins_wake(4'h3, 1'b1);
    rdchk("p3 data", IDX_PORT3_DATA, 8'h03);
    rdchk("status", IDX_WAKE_REF_STATUS, 8'h04);
    pins_wake(4'h3, 1'b0);
    pins_wake(4'hb, 1'b1);
  endtask

  task automatic t_clear();
    wb(1'b1, IDX_WAKE_REF_STATUS, 8'h0c);
    rdchk("status", IDX_WAKE_REF_STATUS, 8'h04);
    wb(1'b1, IDX_WAKE_REF_STATUS, 8'h00);
    rdchk("status", IDX_WAKE_REF_STATUS, 8'h00);
    pins_wake(4'hf, 1'b0);
    pins_wake(4'h7, 1'b1);
  endtask

  // port 2 reference from read and write, then a wake from it
  task automatic t_port2();
    pins_wake(4'hf, 1'b0);
    rdchk("p2 data", IDX_PORT2_DATA, 8'h5a);
    rdchk("status", IDX_WAKE_REF_STATUS, 8'h01);
    wb(1'b1, IDX_PORT2_DATA, 8'ha5);
    rdchk("status", IDX_WAKE_REF_STATUS, 8'h02);
    check("p2 out", {24'h0, port2_out_o}, 32'ha5);
    wb(1'b1, IDX_PORT2_WAKE_SEL, 8'h01);
    pins_wake(4'hf, 1'b1);
    wb(1'b1, IDX_PORT2_DATA, 8'h5a);
    pins_wake(4'hf, 1'b0);
    wb(1'b1, IDX_PORT2_WAKE_SEL, 8'h00);
  endtask

  // sticky hit, masked level, both enables
  task automatic t_irq();
    pins_wake(4'hf, 1'b0);
    wb(1'b1, IDX_IRQ_MASK, 8'h01);
    wb(1'b1, IDX_IRQ_STATUS, 8'h07);
    wb(1'b1, IDX_WAKE_REF_STATUS, 8'h10);
    pins_wake(4'h7, 1'b1);
    check("irq", {31'h0, wake_irq_line_o}, 32'h1);
    pins_wake(4'hf, 1'b0);
    check("irq", {31'h0, wake_irq_line_o}, 32'h1);
    wb(1'b1, IDX_IRQ_STATUS, 8'h01);
    @(negedge clk_i);
    check("irq", {31'h0, wake_irq_line_o}, 32'h0);
    wb(1'b1, IDX_WAKE_REF_STATUS, 8'h00);
    pins_wake(4'h7, 1'b1);
    rdchk("irq stat", IDX_IRQ_STATUS, 8'h01);
    check("irq", {31'h0, wake_irq_line_o}, 32'h0);
    wb(1'b1, IDX_PORT3_MODE, 8'h02);
    @(negedge clk_i);
    check("irq", {31'h0, wake_irq_line_o}, 32'h1);
  endtask

  // gated source: ignored pins are neutral, level bit decides
  task automatic t_gated();
    wb(1'b1, IDX_GATED_WAKE_SEL, 8'h4c);
    rdchk("gated", IDX_GATED_WAKE_SEL, 8'h4c);
    pins_wake(4'hf, 1'b1);
    wb(1'b1, IDX_PORT3_WAKE_SEL, 8'h00);
    pins_wake(4'hf, 1'b0);
    pins_wake(4'h1, 1'b1);
    wb(1'b1, IDX_PORT3_DIR, 8'h0e);
    pins_wake(4'hf, 1'b1);
    wb(1'b1, IDX_GATED_WAKE_SEL, 8'h14);
    pins_wake(4'hf, 1'b1);
    wb(1'b1, IDX_GATED_WAKE_SEL, 8'h08);
    pins_wake(4'hf, 1'b0);
  endtask

  // main sequence; status writes keep bits 7:5 zero
  initial
  begin
    rst_i    = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i  = 1'b0;
    wb_adr_i = 14'h0;
    wb_sel_i = 4'h1;
    wb_dat_i = 32'h0;
    p3_lvl   = 4'hf;
    p2_lvl   = 8'h5a;
    num_errors = 0;
    checks     = 0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_select();
    t_write_ref();
    t_read_ref();
    t_clear();
    t_port2();
    t_irq();
    t_gated();
    test_done();
  end
endmodule
`default_nettype wire
